/* verilog/vme_slave_chain.sv */
/*
 * vme slave address decode, multicast write and chained read token logic.
 * assumes decoded vme cycle phases arrive as synchronous strobes.
 */
// Notes on behaviour
// RQ1: a24 base access answers address modifiers 0x38 to 0x3F.
// RQ2: a32 base access answers address modifiers 0x08 to 0x0F.
// RQ3: base match uses a[23:16] in a24, a[31:16] in a32.
// RQ4: base address comes from four rotary switch inputs.
// RQ5: multicast access is a32 only with modifiers 0x0E, 0x0D, 0x0A, 0x09.
// RQ6: chained reads accept modifiers 0x0F, 0x0C, 0x0B, 0x08.
// RQ7: multicast writes hit every board at once, write only, allowed registers; code pulses mcst_wr only on the first board or while token_in is high.
// RQ8: chained access is block read only, output buffer data only.
// RQ9: chain address byte is software written, resets to 0xAA.
// RQ10: chained decode needs a[31:24] equal chain byte and a[23:16] zero.
// RQ11: token passes over the acknowledge daisy chain; only holder moves data.
// RQ12: first and last flags give inactive, last, first or intermediate role.
// RQ13: reset clears both role flags, board inactive.
// RQ14: software sets exactly one first and one last board per chain.
// RQ15: separate chains in one crate use distinct chain addresses.
// RQ16: chained data framed by header and trailer with slot id in top bits.
// RQ17: power-up empties output buffer and loads all default settings.
// RQ18: converter settings take their documented default codes at power-up.
// RQ19: software reprograms the board after power-up or hardware reset.
// RQ20: full, error and data lamps lit while configuring, then all off.
// RQ21: empty or inactive board passes the token without sending data; code raises token_out only from CB_PASS, which an inactive board never enters.
// RQ22: last board raises bus error after its final data in chained read.
// RQ23: no response to modifiers or addresses outside recognised sets.
`timescale 1ns/100ps
module vme_slave_chain #(
    parameter int DEPTH = 8,
    parameter int CFG_CYCLES = vme_slave_pkg::CONFIG_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] rot_sw0,
    input wire logic [3:0] rot_sw1,
    input wire logic [3:0] rot_sw2,
    input wire logic [3:0] rot_sw3,
    input wire logic cyc_start,
    input wire vme_slave_pkg::bus_req_s req,
    input wire logic beat,
    input wire logic cyc_end,
    input wire logic token_in,
    input wire logic [7:0] chain_addr_in,
    input wire logic chain_addr_we,
    input wire logic [1:0] role_in,
    input wire logic role_we,
    input wire logic [4:0] slot_id_in,
    input wire logic slot_id_we,
    input wire logic evt_valid,
    output logic evt_ready,
    input wire logic [31:0] evt_data,
    input wire logic full_in,
    input wire logic error_in,
    output logic base_sel,
    output logic mcst_sel,
    output logic cblt_sel,
    output logic mcst_wr,
    output logic [15:0] reg_offset,
    output logic [31:0] mcst_wdata,
    output logic [31:0] rdata,
    output logic dtack,
    output logic berr,
    output logic token_out,
    output logic [1:0] role,
    output logic [7:0] chain_addr,
    output logic configuring,
    output logic full_lamp,
    output logic error_lamp,
    output logic data_present_lamp,
    output logic supply_lamp,
    output vme_slave_pkg::conv_cfg_s conv_cfg
);
    import vme_slave_pkg::*;

    typedef enum {CB_IDLE, CB_WAIT, CB_HEAD, CB_DATA, CB_TRAIL,
        CB_PASS, CB_BERR} cb_e;

    localparam int CW = $clog2(CFG_CYCLES + 1);

    cb_e state_reg, state_next;
    logic [CW-1:0] cfg_cnt_reg;
    logic [4:0] slot_id_reg;
    logic [7:0] evt_cnt_reg;
    logic cfg_done;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic chain_active;

    // base address from rotary switches
    wire [15:0] sw_base = {rot_sw3, rot_sw2, rot_sw1, rot_sw0}; // see RQ4
    wire [5:0] am = req.am;
    wire am_a24 = (am >= AM_A24_LO) && (am <= AM_A24_HI); // see RQ1
    wire am_a32 = (am >= AM_A32_LO) && (am <= AM_A32_HI); // see RQ2
    wire hit_a24 = am_a24 && (req.addr[23:16] == sw_base[7:0]); // see RQ3
    wire hit_a32 = am_a32 && (req.addr[31:16] == sw_base); // see RQ3
    wire chain_addr_hit = (req.addr[31:24] == chain_addr)
        && (req.addr[23:16] == CHAIN_MID_ZERO); // see RQ10
    wire am_mcst = (am == AM_MCST_SD) || (am == AM_MCST_SB)
        || (am == AM_MCST_UD) || (am == AM_MCST_UB); // see RQ5
    wire am_cblt = (am == AM_CBLT_SB) || (am == AM_CBLT_S64)
        || (am == AM_CBLT_UB) || (am == AM_CBLT_U64); // see RQ6
    wire dec_mcst = chain_active && chain_addr_hit && am_mcst
        && req.write; // see RQ7
    wire dec_cblt = chain_active && chain_addr_hit && am_cblt
        && !req.write; // see RQ8
    // chain window shadows the ordinary base decode
    wire dec_base = (hit_a24 || hit_a32) && !chain_addr_hit; // see RQ23
    wire holds_token = (role == 2'b10) || token_in; // see RQ11
    wire is_last = (role == 2'b01);

    assign chain_active = (role != 2'b00); // see RQ12
    assign cfg_done = (cfg_cnt_reg == CW'(CFG_CYCLES));

    word_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_obuf (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(!cfg_done), // see RQ17
        .in_valid(evt_valid),
        .in_ready(evt_ready),
        .in_data(evt_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    assign fifo_out_ready = (state_reg == CB_DATA) && beat;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CB_IDLE: begin
                if (cyc_start && dec_cblt) begin
                    state_next = CB_WAIT;
                end
            end
            CB_WAIT: begin
                if (holds_token) begin
                    state_next = fifo_out_valid ? CB_HEAD : CB_PASS; // see RQ21
                end
            end
            CB_HEAD: begin
                if (beat) begin
                    state_next = CB_DATA;
                end
            end
            CB_DATA: begin
                if (!fifo_out_valid || (beat && evt_cnt_reg == 8'hFF)) begin
                    state_next = CB_TRAIL;
                end
            end
            CB_TRAIL: begin
                if (beat) begin
                    state_next = is_last ? CB_BERR : CB_PASS; // see RQ22
                end
            end
            CB_PASS: begin
                state_next = is_last ? CB_BERR : CB_PASS;
            end
            CB_BERR: begin
                state_next = CB_BERR;
            end
            default: begin
                state_next = CB_IDLE;
            end
        endcase
        if (cyc_end) begin
            state_next = CB_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= CB_IDLE;
            evt_cnt_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (state_reg == CB_HEAD) begin
                evt_cnt_reg <= 8'h00;
            end else if (fifo_out_ready && fifo_out_valid) begin
                evt_cnt_reg <= evt_cnt_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_cnt_reg <= '0;
        end else if (!cfg_done) begin
            cfg_cnt_reg <= cfg_cnt_reg + 1'b1;
        end
    end

    // software written chain settings
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chain_addr <= CHAIN_ADDR_RST; // see RQ9
            role <= 2'b00; // see RQ13
            slot_id_reg <= SLOT_ID_RST;
        end else begin
            if (chain_addr_we) begin
                chain_addr <= chain_addr_in; // see RQ9
            end
            if (role_we) begin
                role <= role_in; // see RQ12
            end
            if (slot_id_we) begin
                slot_id_reg <= slot_id_in; // see RQ16
            end
        end
    end

    // converter defaults
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            conv_cfg.match_on <= MATCH_ON_RST; // see RQ18
            conv_cfg.win_width <= WIN_WIDTH_RST;
            conv_cfg.win_offset <= WIN_OFFSET_RST;
            conv_cfg.extra_search <= EXTRA_SEARCH_RST;
            conv_cfg.reject_margin <= REJECT_MARGIN_RST;
            conv_cfg.edge_mode <= EDGE_LEADING;
            conv_cfg.ro_fifo_size <= RO_FIFO_256;
        end
    end

    wire [31:0] head_word = {slot_id_reg, TAG_HEADER, 23'h000000};
    wire [31:0] trail_word = {slot_id_reg, TAG_TRAILER, 15'h0000,
        evt_cnt_reg};
    wire [31:0] rdata_next = (state_reg == CB_HEAD) ? head_word
        : (state_reg == CB_TRAIL) ? trail_word
        : (state_reg == CB_DATA && fifo_out_valid) ? fifo_out_data
        : {TAG_FILLER, 28'h0000000}; // see RQ16
    wire moving = (state_reg == CB_HEAD) || (state_reg == CB_TRAIL)
        || (state_reg == CB_DATA && fifo_out_valid);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            base_sel <= 1'b0;
            mcst_sel <= 1'b0;
            cblt_sel <= 1'b0;
            mcst_wr <= 1'b0;
            reg_offset <= 16'h0000;
            mcst_wdata <= 32'h00000000;
        end else begin
            if (cyc_start) begin
                base_sel <= dec_base; // see RQ23
                mcst_sel <= dec_mcst;
                cblt_sel <= dec_cblt;
                reg_offset <= req.addr[15:0]; // see RQ10
                mcst_wdata <= req.wdata;
            end else if (cyc_end) begin
                base_sel <= 1'b0;
                mcst_sel <= 1'b0;
                cblt_sel <= 1'b0;
            end
            mcst_wr <= cyc_start && dec_mcst && holds_token; // see RQ7
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata <= 32'h00000000;
            dtack <= 1'b0;
            berr <= 1'b0;
            token_out <= 1'b0;
        end else begin
            rdata <= rdata_next;
            dtack <= beat && moving; // see RQ11
            berr <= (state_next == CB_BERR); // see RQ22
            token_out <= (state_reg == CB_PASS) && !is_last; // see RQ21
        end
    end

    // lamps lit during configuration
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            configuring <= 1'b1;
            full_lamp <= 1'b1;
            error_lamp <= 1'b1;
            data_present_lamp <= 1'b1;
            supply_lamp <= 1'b1;
        end else begin
            configuring <= !cfg_done; // see RQ20
            full_lamp <= !cfg_done || full_in;
            error_lamp <= !cfg_done || error_in;
            data_present_lamp <= !cfg_done || fifo_out_valid;
            supply_lamp <= 1'b1;
        end
    end
endmodule

/* verilog/vme_slave_pkg.sv */
/*
 * constants and carrier types for the vme slave address and chain block.
 * assumes a single 25 mhz system clock and synchronous active-high reset.
 */
package vme_slave_pkg;
    localparam logic [5:0] AM_A24_LO = 6'h38;
    localparam logic [5:0] AM_A24_HI = 6'h3F;
    localparam logic [5:0] AM_A32_LO = 6'h08;
    localparam logic [5:0] AM_A32_HI = 6'h0F;
    localparam logic [5:0] AM_MCST_SD = 6'h0E;
    localparam logic [5:0] AM_MCST_SB = 6'h0D;
    localparam logic [5:0] AM_MCST_UD = 6'h0A;
    localparam logic [5:0] AM_MCST_UB = 6'h09;
    localparam logic [5:0] AM_CBLT_SB = 6'h0F;
    localparam logic [5:0] AM_CBLT_S64 = 6'h0C;
    localparam logic [5:0] AM_CBLT_UB = 6'h0B;
    localparam logic [5:0] AM_CBLT_U64 = 6'h08;
    localparam logic [7:0] CHAIN_ADDR_RST = 8'hAA;
    localparam logic [7:0] CHAIN_MID_ZERO = 8'h00;
    localparam logic [4:0] SLOT_ID_RST = 5'h00;
    localparam int SLOT_ID_MSB = 31;
    localparam int SLOT_ID_LSB = 27;
    localparam logic [3:0] TAG_HEADER = 4'h8;
    localparam logic [3:0] TAG_TRAILER = 4'h4;
    localparam logic [3:0] TAG_FILLER = 4'hC;
    localparam logic [0:0] MATCH_ON_RST = 1'h0;
    localparam logic [11:0] WIN_WIDTH_RST = 12'h014;
    localparam logic [15:0] WIN_OFFSET_RST = 16'hFFD8;
    localparam logic [11:0] EXTRA_SEARCH_RST = 12'h008;
    localparam logic [11:0] REJECT_MARGIN_RST = 12'h004;
    localparam logic [1:0] EDGE_LEADING = 2'h2;
    localparam logic [2:0] RO_FIFO_256 = 3'h7;
    localparam int CONFIG_TIME_US = 2000;
    localparam int CLK_MHZ = 25;
    localparam int CONFIG_CYCLES = CONFIG_TIME_US * CLK_MHZ;

    typedef enum {ROLE_INACTIVE, ROLE_LAST, ROLE_FIRST, ROLE_MID} role_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [5:0] am;
        logic write;
        logic [31:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic match_on;
        logic [11:0] win_width;
        logic [15:0] win_offset;
        logic [11:0] extra_search;
        logic [11:0] reject_margin;
        logic [1:0] edge_mode;
        logic [2:0] ro_fifo_size;
    } conv_cfg_s;
endpackage

/* verilog/word_fifo.sv */
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock and synchronous active-high reset; clear empties it.
 */
`timescale 1ns/100ps
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rd_reg];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || clear) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* tb/vme_slave_chain_sva.sv */
/* assertion checker for the vme slave address and chain block ports.
   assumes one clock with sync active-high reset; bound after the module. */
`timescale 1ns/100ps
module vme_slave_chain_sva import vme_slave_pkg::*; #(
    parameter int DEPTH = 8,
    parameter int CFG_CYCLES = 10
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] rot_sw0,
    input wire logic [3:0] rot_sw1,
    input wire logic [3:0] rot_sw2,
    input wire logic [3:0] rot_sw3,
    input wire logic cyc_start,
    input wire vme_slave_pkg::bus_req_s req,
    input wire logic beat,
    input wire logic cyc_end,
    input wire logic base_sel,
    input wire logic mcst_sel,
    input wire logic cblt_sel,
    input wire logic mcst_wr,
    input wire logic [15:0] reg_offset,
    input wire logic dtack,
    input wire logic berr,
    input wire logic token_out,
    input wire logic [1:0] role,
    input wire logic [7:0] chain_addr,
    input wire logic configuring,
    input wire logic full_lamp,
    input wire logic data_present_lamp
);
    wire logic win = req.addr[31:24] == chain_addr
        && req.addr[23:16] == CHAIN_MID_ZERO;
    wire logic base_hit = (req.am inside {[AM_A24_LO:AM_A24_HI]}
        && req.addr[23:16] == {rot_sw1, rot_sw0})
        || (req.am inside {[AM_A32_LO:AM_A32_HI]} && !win
        && req.addr[31:16] == {rot_sw3, rot_sw2, rot_sw1, rot_sw0});
    wire logic mc_hit = req.write && win && role != 2'h0
        && req.am inside {AM_MCST_SD, AM_MCST_SB, AM_MCST_UD, AM_MCST_UB};
    wire logic cb_hit = !req.write && win && role != 2'h0
        && req.am inside {AM_CBLT_SB, AM_CBLT_S64, AM_CBLT_UB, AM_CBLT_U64};
    logic [31:0] cfg_cnt;
    always_ff @(posedge clk_sys) begin
        cfg_cnt <= rst ? 32'h0 : cfg_cnt + 32'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_base_decode: assert property (
        cyc_start |=> base_sel == $past(base_hit)) else $error("base decode");
    a_mcst_decode: assert property (
        cyc_start |=> mcst_sel == $past(mc_hit)) else $error("mcst decode");
    a_cblt_decode: assert property (
        cyc_start |=> cblt_sel == $past(cb_hit)) else $error("cblt decode");
    a_offset_taken: assert property (
        cyc_start && (mc_hit || cb_hit) |=> reg_offset == $past(req.addr[15:0]))
        else $error("offset");
    a_dtack_cause: assert property (
        dtack |-> $past(beat) && cblt_sel) else $error("dtack cause");
    a_wr_single: assert property (
        mcst_wr |=> !mcst_wr) else $error("mcst pulse");
    a_berr_last: assert property (
        berr |-> role == 2'h1) else $error("berr role");
    a_berr_holds: assert property (
        berr && !cyc_end |=> berr) else $error("berr hold");
    a_token_role: assert property (
        token_out |-> role != 2'h1) else $error("token role");
    a_reset_vals: assert property (disable iff (1'b0)
        rst |=> chain_addr == CHAIN_ADDR_RST && role == 2'h0 && configuring)
        else $error("reset values");
    a_lamps_lit: assert property (
        configuring |-> full_lamp && data_present_lamp) else $error("lamps");
    a_config_ends: assert property (
        cfg_cnt > 32'(CFG_CYCLES + 2) |-> !configuring) else $error("config");
    cover property (cblt_sel && dtack);
    cover property (mcst_wr);
    cover property (berr);
    cover property (token_out);
endmodule
bind vme_slave_chain vme_slave_chain_sva #(.DEPTH(DEPTH),
    .CFG_CYCLES(CFG_CYCLES)) chk_inst (.*);

/* tb/vme_master_model.sv */
/* bus master and neighbour token model for the slave chain block.
   assumes the bench calls its tasks; signals move on falling edges. */
`timescale 1ns/100ps
module vme_master_model import vme_slave_pkg::*; (
    input wire logic clk_sys,
    input wire logic dtack,
    input wire logic [31:0] rdata,
    output vme_slave_pkg::bus_req_s req,
    output logic cyc_start,
    output logic beat,
    output logic cyc_end,
    output logic token_in
);
    initial begin
        req = '0;
        {cyc_start, beat, cyc_end, token_in} = 4'h0;
    end
    task automatic start(input logic [31:0] a, input logic [5:0] m,
        input logic w, input logic [31:0] d);
        @(negedge clk_sys);
        req = '{a, m, w, d};
        cyc_start = 1'b1;
        @(negedge clk_sys);
        cyc_start = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic take(input int stall, output logic [31:0] w,
        output logic ok);
        repeat (stall) @(negedge clk_sys);
        beat = 1'b1;
        @(negedge clk_sys);
        beat = 1'b0;
        ok = dtack;
        w = rdata;
    endtask
    task automatic finish();
        @(negedge clk_sys);
        cyc_end = 1'b1;
        @(negedge clk_sys);
        cyc_end = 1'b0;
        req = ~req;
    endtask
    task automatic pass_token(input logic t);
        @(negedge clk_sys);
        token_in = t;
    endtask
endmodule

/* tb/tb_vme_slave_chain.sv */
/* self-checking bench for the vme slave address and chain block.
   assumes the master model in tb/ and a shortened configuring time. */
`timescale 1ns/100ps
module tb_vme_slave_chain import vme_slave_pkg::*; ;
    logic clk_sys, rst, cyc_start, beat, cyc_end, token_in, ok;
    logic [3:0] rot_sw0, rot_sw1, rot_sw2, rot_sw3;
    bus_req_s req;
    logic [7:0] chain_addr_in, chain_addr;
    logic [1:0] role_in, role;
    logic [4:0] slot_id_in;
    logic chain_addr_we, role_we, slot_id_we, evt_valid, evt_ready;
    logic [31:0] evt_data, mcst_wdata, rdata, w;
    logic full_in, error_in, base_sel, mcst_sel, cblt_sel, mcst_wr, dtack;
    logic berr, token_out, configuring, full_lamp, error_lamp;
    logic data_present_lamp, supply_lamp;
    logic [15:0] reg_offset;
    conv_cfg_s conv_cfg;
    int errors, check_count, wr_seen, i, n, dt;
    vme_slave_chain #(.DEPTH(8), .CFG_CYCLES(10)) vme_slave_chain_inst (.*);
    vme_master_model vme_master_model_inst (.*);
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (mcst_wr === 1'b1) wr_seen++;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wait_ok(input logic good);
        chk(64'(good), 64'h1);
        if (!good) conclude();
    endtask
    task automatic put_cfg(input logic [7:0] c, input logic [1:0] r);
        @(negedge clk_sys);
        {chain_addr_in, role_in, chain_addr_we, role_we} = {c, r, 2'h3};
        @(negedge clk_sys);
        {chain_addr_we, role_we} = 2'h0;
        @(negedge clk_sys);
        chk(64'({chain_addr, role}), 64'({c, r}));
    endtask
    task automatic base_try(input logic [31:0] a, input logic [5:0] m,
        input logic e);
        vme_master_model_inst.start(a, m, 1'b0, 32'h0);
        chk(64'({base_sel, mcst_sel, cblt_sel}), 64'({e, 2'h0}));
        vme_master_model_inst.finish();
    endtask
    task automatic t_defaults();
        chk(64'({chain_addr, role}), 64'({CHAIN_ADDR_RST, 2'h0}));
        chk(64'({supply_lamp, full_lamp, error_lamp, data_present_lamp}), 64'hF);
        chk(64'(conv_cfg), 64'({MATCH_ON_RST, WIN_WIDTH_RST, WIN_OFFSET_RST,
            EXTRA_SEARCH_RST, REJECT_MARGIN_RST, EDGE_LEADING,
            RO_FIFO_256}));
        chk(64'(evt_ready), 64'h1);
        for (n = 0; n < 40 && configuring !== 1'b0; n++) @(negedge clk_sys);
        wait_ok(n < 40);
        chk(64'({full_lamp, error_lamp, data_present_lamp}), 64'h0);
    endtask
    task automatic t_base();
        for (i = 0; i < 64; i++)
            base_try(32'hCC110010, 6'(i), (i >= 8'h38 && i <= 8'h3F)
                || (i >= 8'h08 && i <= 8'h0F));
        base_try(32'h00110010, 6'h39, 1'b1);
        base_try(32'hCD110010, 6'h09, 1'b0);
        rot_sw2 = 4'hD;
        base_try(32'hCD110010, 6'h09, 1'b1);
        rot_sw2 = 4'hC;
    endtask
    task automatic t_mcst();
        logic [5:0] ams [4];
        ams = '{AM_MCST_SD, AM_MCST_SB, AM_MCST_UD, AM_MCST_UB};
        put_cfg(8'h5B, 2'h2);
        for (i = 0; i < 4; i++) begin
            vme_master_model_inst.start(32'h5B000024, ams[i], 1'b1,
                32'h12345600 + 32'(i));
            chk(64'({mcst_sel, base_sel, reg_offset}), 64'h20024);
            vme_master_model_inst.finish();
            chk(64'({wr_seen, mcst_wdata}), 64'({i + 1, 32'h12345600 + 32'(i)}));
        end
        vme_master_model_inst.start(32'h5B010024, AM_MCST_SD, 1'b1, 32'h0);
        chk(64'(mcst_sel), 64'h0);
        vme_master_model_inst.finish();
        put_cfg(8'h5B, 2'h0);
        base_try(32'h5B000024, AM_MCST_SD, 1'b0);
    endtask
    task automatic t_cblt();
        @(negedge clk_sys);
        {slot_id_in, slot_id_we, evt_valid} = {5'h13, 2'h3};
        for (i = 0; i < 9; i++) begin
            evt_data = 32'h1000 + 32'(i);
            @(negedge clk_sys);
            slot_id_we = 1'b0;
            if (evt_ready !== 1'b1) break;
        end
        evt_valid = 1'b0;
        chk(64'({evt_ready, i}), 64'h7);
        put_cfg(8'h5B, 2'h1);
        vme_master_model_inst.pass_token(1'b1);
        vme_master_model_inst.start(32'h5B000000, AM_CBLT_SB, 1'b0, 32'h0);
        chk(64'(cblt_sel), 64'h1);
        vme_master_model_inst.take(3, w, ok);
        chk(64'({ok, w[31:23]}), 64'({1'b1, 5'h13, TAG_HEADER}));
        for (i = 0; i < 8; i++) begin
            vme_master_model_inst.take(i % 3, w, ok);
            chk(64'({ok, w}), 64'({1'b1, 32'h1000 + 32'(i)}));
        end
        vme_master_model_inst.take(2, w, ok);
        chk(64'({ok, w[31:23], w[7:0]}),
            64'({1'b1, 5'h13, TAG_TRAILER, 8'h08}));
        vme_master_model_inst.take(0, w, ok);
        chk(64'({berr, token_out}), 64'h2);
        vme_master_model_inst.finish();
    endtask
    task automatic t_pass();
        logic [5:0] ams [4];
        ams = '{AM_CBLT_SB, AM_CBLT_S64, AM_CBLT_UB, AM_CBLT_U64};
        put_cfg(8'h5B, 2'h3);
        for (i = 0; i < 4; i++) begin
            vme_master_model_inst.start(32'h5B000000, ams[i], 1'b0, 32'h0);
            chk(64'(cblt_sel), 64'h1);
            dt = 0;
            for (n = 0; n < 6 && token_out !== 1'b1; n++) begin
                vme_master_model_inst.take(1, w, ok);
                if (ok === 1'b1) dt++;
            end
            wait_ok(token_out === 1'b1);
            chk(64'(dt), 64'h0);
            vme_master_model_inst.finish();
        end
    endtask
    initial begin
        {rst, chain_addr_we, role_we, slot_id_we, evt_valid} = 5'h10;
        {full_in, error_in, chain_addr_in, role_in, slot_id_in} = '0;
        {rot_sw3, rot_sw2, rot_sw1, rot_sw0} = 16'hCC11;
        evt_data = 32'h0;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        t_defaults();
        t_base();
        t_mcst();
        t_cblt();
        t_pass();
        conclude();
    end
endmodule
